// ---- tws_pkg.sv ----
package tws_pkg;

	// ********************************
	// Register offsets (byte addresses)
	// ********************************
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_CTRL1  = 8'h04;
	localparam logic [7:0] OFS_CTRL2  = 8'h08;
	localparam logic [7:0] OFS_BUF    = 8'h0C;
	localparam logic [7:0] OFS_ADDR   = 8'h10;
	localparam logic [7:0] OFS_EVENT  = 8'h14;
	localparam logic [7:0] OFS_PINCFG = 8'h18;

	// ********************************
	// Field layouts
	// ********************************
	typedef struct packed {
		logic slew_limit_off;
		logic smbus_inputs;
		logic data_addr;
		logic stop_seen;
		logic start_seen;
		logic read_write;
		logic update_address_flag;
		logic buffer_full_flag;
	} tws_status_t;

	typedef struct packed {
		logic       write_collision_flag;
		logic       receive_overflow_flag;
		logic       port_enable;
		logic       clock_release;
		logic [3:0] mode_select_field;
	} tws_ctrl1_t;

	typedef struct packed {
		logic general_call_enable;
		logic ack_received_status;
		logic ack_data_value;
		logic ack_sequence_enable;
		logic master_receive_enable;
		logic stop_condition_enable;
		logic repeated_start_enable;
		logic start_or_stretch_enable;
	} tws_ctrl2_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} tws_line_t;

	// ********************************
	// Reset values and codes
	// ********************************
	localparam tws_status_t STATUS_RST = 8'h00;
	localparam tws_ctrl1_t  CTRL1_RST  = 8'h00;
	localparam tws_ctrl2_t  CTRL2_RST  = 8'h00;
	localparam logic [1:0]  PINCFG_RST = 2'h3;
	localparam logic [7:0]  GENERAL_CALL = 8'h00;
	localparam logic [4:0]  EVENT_PAD    = 5'h00;

	localparam logic [3:0] MODE_SLV7     = 4'h6;
	localparam logic [3:0] MODE_SLV10    = 4'h7;
	localparam logic [3:0] MODE_MASTER   = 4'h8;
	localparam logic [3:0] MODE_FW_MSTR  = 4'hB;
	localparam logic [3:0] MODE_SLV7_SP  = 4'hE;
	localparam logic [3:0] MODE_SLV10_SP = 4'hF;

	localparam logic [3:0] TX_LAST_BIT  = 4'h8;
	localparam logic [3:0] RX_LAST_BIT  = 4'h7;
	localparam logic [3:0] SLV_ACK_BIT  = 4'h8;
	localparam logic [3:0] SLV_LAST_BIT = 4'h7;

	typedef enum logic [6:0] {
		M_IDLE   = 7'h01,
		M_START  = 7'h02,
		M_RSTART = 7'h04,
		M_STOP   = 7'h08,
		M_TX     = 7'h10,
		M_RX     = 7'h20,
		M_ACK    = 7'h40
	} tws_mst_t;

endpackage : tws_pkg

// ---- tws_baud.sv ----
`timescale 1ns/10ps
module tws_baud #(
	parameter int W = 8
) (
	input  wire logic         pclk,    // System clock.
	input  wire logic         presetn, // Asynchronous reset, active low.
	input  wire logic         run,     // Count while high.
	input  wire logic [W-1:0] reload,  // Quarter period minus one.
	output logic              tick     // One-cycle quarter-period pulse.
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} tws_baud_st_t;

	tws_baud_st_t q;
	tws_baud_st_t n;

	assign tick = run && (q.cnt == reload);

	always_comb begin
		n = q;
		if (!run || tick) begin
			n.cnt = '0;
		end else begin
			n.cnt = q.cnt + W'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end
endmodule : tws_baud

// ---- tws_busmon.sv ----
`timescale 1ns/10ps
module tws_busmon (
	input  wire logic                pclk,    // System clock.
	input  wire logic                presetn, // Asynchronous reset, active low.
	input  wire tws_pkg::tws_line_t  line,    // Bus levels.
	output logic                     rise,    // Clock rose.
	output logic                     fall,    // Clock fell.
	output logic                     start,   // Start condition seen.
	output logic                     stop     // Stop condition seen.
);
	typedef struct packed {
		tws_pkg::tws_line_t prev;
	} tws_mon_st_t;

	tws_mon_st_t q;
	tws_mon_st_t n;

	assign rise  = !q.prev.scl && line.scl;
	assign fall  = q.prev.scl && !line.scl;
	assign start = q.prev.scl && line.scl && q.prev.sda && !line.sda;
	assign stop  = q.prev.scl && line.scl && !q.prev.sda && line.sda;

	always_comb begin
		n = q;
		n.prev = line;
	end

	// Idle bus is high, so reset to high avoids a false edge at release.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= 2'h3;
		end else begin
			q <= n;
		end
	end
endmodule : tws_busmon

// ---- tws_ctrl.sv ----
// How it works
// - Slave data/address flag tracks last byte kind.
// - Start and stop flags show latest condition.
// - Reset or disable clears start/stop flags.
// - Slave captures read/write of matched address.
// - Master read/write bit shows transmit in progress.
// - Ten-bit slave raises update-address flag.
// - Buffer-full flag tracks held data byte.
// - Sticky write collision on illegal buffer write.
// - Sticky overflow when data byte arrives buffer full.
// - Enable bit hands pins to the port.
// - Slave holds clock low until released.
// - Four-bit mode field selects master or slave.
// - Master clock is pclk over four times reload-plus-one.
// - General call recognised only when enabled.
// - Master transmit records slave acknowledge.
// - Acknowledge sequence sends chosen bit, self-clears.
// - Receive enable clocks in one byte.
// - Start, repeated start, stop generated, self-clear.
// - Slave stretch enable shares start bit.
// - Busy master refuses enables and buffer writes.
// - Enabled pins are open-drain, externally pulled up.
// - Address register is reload or own address.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module tws_ctrl #(
	parameter int AW = 8
) (
	input  wire logic               pclk,     // System clock.
	input  wire logic               presetn,  // Asynchronous reset, active low.
	input  wire logic               psel,     // APB select.
	input  wire logic               penable,  // APB access phase.
	input  wire logic               pwrite,   // APB write.
	input  wire logic [AW-1:0]      paddr,    // APB byte address.
	input  wire logic [31:0]        pwdata,   // APB write data.
	output logic [31:0]             prdata,   // APB read data.
	output logic                    pready,   // APB ready.
	output logic                    pslverr,  // APB error on unmapped address.
	input  wire tws_pkg::tws_line_t pin_in,   // Levels on the bus wires.
	output tws_pkg::tws_line_t      pin_out,  // Output value, always low.
	output tws_pkg::tws_line_t      pin_oe_n, // Low while pulling a wire low.
	output logic                    pins_owned // Port owns the pins.
);
	// ********************************
	// State
	// ********************************
	typedef struct packed {
		tws_pkg::tws_status_t stat;
		tws_pkg::tws_ctrl1_t  c1;
		tws_pkg::tws_ctrl2_t  c2;
		logic [7:0]           dbuf;
		logic [7:0]           sr;
		logic [7:0]           addr;
		logic                 evt;
		logic [1:0]           pincfg;
		tws_pkg::tws_mst_t    mst;
		logic [1:0]           ph;
		logic [3:0]           bitn;
		logic                 owned;
		logic                 m_scl;
		logic                 m_sda;
		logic                 s_act;
		logic                 s_tx;
		logic                 s_addr;
		logic                 s_hi;
		logic                 s_sda;
		logic [3:0]           s_bit;
		logic [31:0]          rdata;
	} tws_ctrl_st_t;

	localparam tws_ctrl_st_t ST_RST = '{
		stat:   tws_pkg::STATUS_RST,
		c1:     tws_pkg::CTRL1_RST,
		c2:     tws_pkg::CTRL2_RST,
		pincfg: tws_pkg::PINCFG_RST,
		mst:    tws_pkg::M_IDLE,
		m_scl:  1'b1,
		m_sda:  1'b1,
		s_sda:  1'b1,
		default: '0
	};

	tws_ctrl_st_t q;
	tws_ctrl_st_t n;

	logic        tick;
	logic        rise;
	logic        fall;
	logic        start;
	logic        stop;
	logic        is_mst;
	logic        is_slv;
	logic        ten;
	logic        enables;
	logic        m_idle;
	logic        s_hold;
	logic        drv_scl;
	logic        drv_sda;
	logic        mapped;
	logic        wr;
	logic        rd;
	logic        gc;
	logic        hit;
	logic [7:0]  a;
	tws_pkg::tws_status_t stat_view;

	// ********************************
	// Helpers
	// ********************************
	tws_baud #(.W(8)) u_baud (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (is_mst && (q.mst != tws_pkg::M_IDLE)),
		.reload  (q.addr),
		.tick    (tick)
	);

	tws_busmon u_mon (
		.pclk    (pclk),
		.presetn (presetn),
		.line    (pin_in),
		.rise    (rise),
		.fall    (fall),
		.start   (start),
		.stop    (stop)
	);

	// ********************************
	// Decode
	// ********************************
	assign a      = paddr[7:0];
	assign is_mst = q.c1.port_enable && (q.c1.mode_select_field == tws_pkg::MODE_MASTER ||
		q.c1.mode_select_field == tws_pkg::MODE_FW_MSTR);
	assign is_slv = q.c1.port_enable && (q.c1.mode_select_field == tws_pkg::MODE_SLV7 ||
		q.c1.mode_select_field == tws_pkg::MODE_SLV10 ||
		q.c1.mode_select_field == tws_pkg::MODE_SLV7_SP ||
		q.c1.mode_select_field == tws_pkg::MODE_SLV10_SP);
	assign ten     = q.c1.mode_select_field[0];
	assign enables = q.c2.ack_sequence_enable | q.c2.master_receive_enable |
		q.c2.stop_condition_enable | q.c2.repeated_start_enable | q.c2.start_or_stretch_enable;
	assign m_idle  = (q.mst == tws_pkg::M_IDLE) && !enables;
	assign gc      = q.c2.general_call_enable && (q.sr == tws_pkg::GENERAL_CALL);
	assign hit     = gc || ((q.sr != tws_pkg::GENERAL_CALL) &&
		(q.s_hi ? (q.sr == q.addr) : (q.sr[7:1] == q.addr[7:1])));
	assign mapped  = (a == tws_pkg::OFS_STATUS) || (a == tws_pkg::OFS_CTRL1) ||
		(a == tws_pkg::OFS_CTRL2) || (a == tws_pkg::OFS_BUF) || (a == tws_pkg::OFS_ADDR) ||
		(a == tws_pkg::OFS_EVENT) || (a == tws_pkg::OFS_PINCFG);
	assign wr      = psel && penable && pwrite && mapped;
	assign rd      = psel && penable && !pwrite && mapped;

	// Stretch only at a byte boundary, so an idle low release bit never blocks addressing.
	assign s_hold  = is_slv && q.s_act && !q.s_addr && !q.c1.clock_release &&
		(q.s_bit == 4'h0);
	assign drv_scl = (is_mst && !q.m_scl) || s_hold;
	assign drv_sda = (is_mst && !q.m_sda) || (is_slv && !q.s_sda);

	always_comb begin
		stat_view = q.stat;
		if (is_mst) begin
			stat_view.read_write = (q.mst == tws_pkg::M_TX);
		end
	end

	// ********************************
	// Outputs
	// ********************************
	assign prdata         = q.rdata;
	assign pready         = psel && penable;
	assign pslverr        = psel && penable && !mapped;
	assign pins_owned     = q.c1.port_enable;
	assign pin_out        = '0;
	assign pin_oe_n.scl   = !(q.c1.port_enable && q.pincfg[1] && drv_scl);
	assign pin_oe_n.sda   = !(q.c1.port_enable && q.pincfg[0] && drv_sda);

	// ********************************
	// Next state
	// ********************************
	always_comb begin
		n = q;

		// Read data is captured in the setup cycle so it comes out of a flip-flop.
		if (psel && !penable) begin
			case (a)
				tws_pkg::OFS_STATUS: n.rdata = {24'h000000, stat_view};
				tws_pkg::OFS_CTRL1:  n.rdata = {24'h000000, q.c1};
				tws_pkg::OFS_CTRL2:  n.rdata = {24'h000000, q.c2};
				tws_pkg::OFS_BUF:    n.rdata = {24'h000000, q.dbuf};
				tws_pkg::OFS_ADDR:   n.rdata = {24'h000000, q.addr};
				tws_pkg::OFS_EVENT:  n.rdata = {25'h0000000, tws_pkg::EVENT_PAD,
					(stat_view.read_write & is_mst) | enables, q.evt};
				tws_pkg::OFS_PINCFG: n.rdata = {30'h00000000, q.pincfg};
				default:             n.rdata = 32'h00000000;
			endcase
		end

		// Software side; hardware events below override, so a set wins over a clear.
		if (rd && (a == tws_pkg::OFS_BUF) && (q.mst != tws_pkg::M_TX) && !q.s_tx) begin
			n.stat.buffer_full_flag = 1'b0;
		end
		if (wr) begin
			case (a)
				tws_pkg::OFS_STATUS: begin
					n.stat.slew_limit_off = pwdata[7];
					n.stat.smbus_inputs   = pwdata[6];
				end
				tws_pkg::OFS_CTRL1: n.c1 = pwdata[7:0];
				tws_pkg::OFS_CTRL2: begin
					n.c2.general_call_enable = pwdata[7];
					n.c2.ack_data_value      = pwdata[5];
					if (!is_mst) begin
						n.c2.start_or_stretch_enable = pwdata[0];
					end else if (m_idle) begin
						n.c2.ack_sequence_enable     = pwdata[4];
						n.c2.master_receive_enable   = pwdata[3];
						n.c2.stop_condition_enable   = pwdata[2];
						n.c2.repeated_start_enable   = pwdata[1];
						n.c2.start_or_stretch_enable = pwdata[0];
					end
				end
				tws_pkg::OFS_BUF: begin
					if (is_mst) begin
						if (m_idle && q.owned) begin
							n.dbuf = pwdata[7:0];
							n.sr   = pwdata[7:0];
							n.stat.buffer_full_flag = 1'b1;
							n.mst  = tws_pkg::M_TX;
							n.ph   = 2'h0;
							n.bitn = 4'h0;
						end else begin
							n.c1.write_collision_flag = 1'b1;
						end
					end else if (is_slv && q.s_tx && (q.s_bit != 4'h0)) begin
						n.c1.write_collision_flag = 1'b1;
					end else begin
						n.dbuf = pwdata[7:0];
						if (q.s_tx) begin
							n.stat.buffer_full_flag = 1'b1;
							n.s_sda = pwdata[7];
							n.sr    = {pwdata[6:0], 1'b0};
						end
					end
				end
				tws_pkg::OFS_ADDR: begin
					n.addr = pwdata[7:0];
					n.stat.update_address_flag = 1'b0;
				end
				tws_pkg::OFS_EVENT: begin
					if (pwdata[0]) begin
						n.evt = 1'b0;
					end
				end
				tws_pkg::OFS_PINCFG: n.pincfg = pwdata[1:0];
				default: ;
			endcase
		end

		// ********************************
		// Master sequencer
		// ********************************
		if (is_mst && (q.mst == tws_pkg::M_IDLE)) begin
			n.ph   = 2'h0;
			n.bitn = 4'h0;
			if (q.c2.start_or_stretch_enable) begin
				n.mst = tws_pkg::M_START;
			end else if (q.c2.repeated_start_enable) begin
				n.mst = tws_pkg::M_RSTART;
			end else if (q.c2.stop_condition_enable) begin
				n.mst = tws_pkg::M_STOP;
			end else if (q.c2.master_receive_enable) begin
				n.mst = tws_pkg::M_RX;
			end else if (q.c2.ack_sequence_enable) begin
				n.mst = tws_pkg::M_ACK;
			end
		end
		// A slave holding the clock low freezes the high quarter until it lets go.
		if (is_mst && tick && (q.mst != tws_pkg::M_IDLE) && !((q.ph == 2'h2) && !pin_in.scl)) begin
			n.ph = q.ph + 2'h1;
			case (q.mst)
				tws_pkg::M_START: begin
					case (q.ph)
						2'h0: begin
							n.m_scl = 1'b1;
							n.m_sda = 1'b1;
						end
						2'h1: n.m_sda = 1'b0;
						2'h2: n.m_scl = 1'b0;
						default: begin
							n.mst   = tws_pkg::M_IDLE;
							n.owned = 1'b1;
							n.evt   = 1'b1;
							n.c2.start_or_stretch_enable = 1'b0;
						end
					endcase
				end
				tws_pkg::M_RSTART: begin
					case (q.ph)
						2'h0: begin
							n.m_scl = 1'b0;
							n.m_sda = 1'b1;
						end
						2'h1: n.m_scl = 1'b1;
						2'h2: n.m_sda = 1'b0;
						default: begin
							n.m_scl = 1'b0;
							n.mst   = tws_pkg::M_IDLE;
							n.evt   = 1'b1;
							n.c2.repeated_start_enable = 1'b0;
						end
					endcase
				end
				tws_pkg::M_STOP: begin
					case (q.ph)
						2'h0: begin
							n.m_scl = 1'b0;
							n.m_sda = 1'b0;
						end
						2'h1: n.m_scl = 1'b1;
						2'h2: n.m_sda = 1'b1;
						default: begin
							n.mst   = tws_pkg::M_IDLE;
							n.owned = 1'b0;
							n.evt   = 1'b1;
							n.c2.stop_condition_enable = 1'b0;
						end
					endcase
				end
				default: begin
					case (q.ph)
						2'h0: begin
							n.m_scl = 1'b0;
							if (q.mst == tws_pkg::M_TX) begin
								n.m_sda = (q.bitn == tws_pkg::TX_LAST_BIT) ? 1'b1 : q.sr[7];
							end else if (q.mst == tws_pkg::M_ACK) begin
								n.m_sda = q.c2.ack_data_value;
							end else begin
								n.m_sda = 1'b1;
							end
						end
						2'h1: n.m_scl = 1'b1;
						2'h2: begin
							if (q.mst == tws_pkg::M_TX && q.bitn == tws_pkg::TX_LAST_BIT) begin
								n.c2.ack_received_status = pin_in.sda;
							end else if (q.mst == tws_pkg::M_RX) begin
								n.sr = {q.sr[6:0], pin_in.sda};
							end
						end
						default: begin
							n.m_scl = 1'b0;
							n.bitn  = q.bitn + 4'h1;
							if (q.mst == tws_pkg::M_TX) begin
								n.sr = {q.sr[6:0], 1'b0};
								if (q.bitn == tws_pkg::TX_LAST_BIT) begin
									n.mst = tws_pkg::M_IDLE;
									n.evt = 1'b1;
									n.stat.buffer_full_flag = 1'b0;
								end
							end else if (q.mst == tws_pkg::M_RX) begin
								if (q.bitn == tws_pkg::RX_LAST_BIT) begin
									n.mst   = tws_pkg::M_IDLE;
									n.m_sda = 1'b1;
									n.evt   = 1'b1;
									n.c2.master_receive_enable = 1'b0;
									if (q.stat.buffer_full_flag) begin
										n.c1.receive_overflow_flag = 1'b1;
									end else begin
										n.dbuf = q.sr;
										n.stat.buffer_full_flag = 1'b1;
									end
								end
							end else begin
								n.mst   = tws_pkg::M_IDLE;
								n.m_sda = 1'b1;
								n.evt   = 1'b1;
								n.c2.ack_sequence_enable = 1'b0;
							end
						end
					endcase
				end
			endcase
		end

		// ********************************
		// Slave
		// ********************************
		if (is_slv) begin
			if (start) begin
				n.s_act  = 1'b1;
				n.s_tx   = 1'b0;
				n.s_addr = 1'b1;
				n.s_bit  = 4'h0;
				n.s_sda  = 1'b1;
				n.stat.read_write = 1'b0;
				n.evt    = q.evt | q.c1.mode_select_field[3];
			end else if (stop) begin
				n.s_act  = 1'b0;
				n.s_tx   = 1'b0;
				n.s_hi   = 1'b0;
				n.s_sda  = 1'b1;
				n.stat.read_write = 1'b0;
				n.evt    = q.evt | q.c1.mode_select_field[3];
			end else if (q.s_act && rise) begin
				if (!q.s_tx && q.s_bit < tws_pkg::SLV_ACK_BIT) begin
					n.sr = {q.sr[6:0], pin_in.sda};
				end else if (q.s_tx && q.s_bit == tws_pkg::SLV_ACK_BIT && pin_in.sda) begin
					n.s_act = 1'b0;
					n.s_tx  = 1'b0;
					n.stat.read_write = 1'b0;
				end
			end else if (q.s_act && fall) begin
				n.s_bit = q.s_bit + 4'h1;
				if (q.s_bit == tws_pkg::SLV_LAST_BIT) begin
					if (q.s_tx) begin
						n.s_sda = 1'b1;
						n.stat.buffer_full_flag = 1'b0;
						n.stat.data_addr = 1'b1;
					end else if (q.s_addr) begin
						if (hit) begin
							n.stat.data_addr = 1'b0;
							n.evt = 1'b1;
							n.stat.update_address_flag = ten && !gc;
							if (!(q.stat.buffer_full_flag || q.c1.receive_overflow_flag)) begin
								n.dbuf  = q.sr;
								n.stat.buffer_full_flag = 1'b1;
								n.s_sda = 1'b0;
							end
							if (!q.s_hi) begin
								n.stat.read_write = q.sr[0];
							end
							if (ten && !q.s_hi && !q.sr[0] && !gc) begin
								n.s_hi = 1'b1;
							end else begin
								n.s_hi   = 1'b0;
								n.s_addr = 1'b0;
							end
							if (q.sr[0] && !gc && !q.s_hi) begin
								n.s_tx = 1'b1;
								n.c1.clock_release = 1'b0;
							end
						end else begin
							n.s_act = 1'b0;
						end
					end else begin
						n.stat.data_addr = 1'b1;
						n.evt = 1'b1;
						if (q.stat.buffer_full_flag || q.c1.receive_overflow_flag) begin
							n.c1.receive_overflow_flag = q.c1.receive_overflow_flag |
								q.stat.buffer_full_flag;
						end else begin
							n.dbuf  = q.sr;
							n.stat.buffer_full_flag = 1'b1;
							n.s_sda = 1'b0;
						end
						if (q.c2.start_or_stretch_enable) begin
							n.c1.clock_release = 1'b0;
						end
					end
				end else if (q.s_bit == tws_pkg::SLV_ACK_BIT) begin
					n.s_sda = 1'b1;
					n.s_bit = 4'h0;
					if (q.s_tx) begin
						n.c1.clock_release = 1'b0;
						n.evt = 1'b1;
					end
				end else if (q.s_tx) begin
					n.s_sda = q.sr[7];
					n.sr    = {q.sr[6:0], 1'b0};
				end
			end
		end

		// ********************************
		// Bus conditions and disable
		// ********************************
		if (start) begin
			n.stat.start_seen = 1'b1;
			n.stat.stop_seen  = 1'b0;
		end else if (stop) begin
			n.stat.stop_seen  = 1'b1;
			n.stat.start_seen = 1'b0;
		end
		if (!n.c1.port_enable) begin
			n.stat.start_seen = 1'b0;
			n.stat.stop_seen  = 1'b0;
			n.mst   = tws_pkg::M_IDLE;
			n.owned = 1'b0;
			n.m_scl = 1'b1;
			n.m_sda = 1'b1;
			n.s_act = 1'b0;
			n.s_tx  = 1'b0;
			n.s_sda = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= ST_RST;
		end else begin
			q <= n;
		end
	end
endmodule : tws_ctrl

// ---- tws_ctrl_sva.sv ----
`timescale 1ns/10ps
module tws_ctrl_sva #(
	parameter int AW = 8
) (
	input wire logic               pclk,      // Clock.
	input wire logic               presetn,   // Reset.
	input wire logic               psel,      // Select.
	input wire logic               penable,   // Access.
	input wire logic               pwrite,    // Write.
	input wire logic [AW-1:0]      paddr,     // Address.
	input wire logic [31:0]        pwdata,    // Write data.
	input wire logic [31:0]        prdata,    // Read data.
	input wire logic               pready,    // Ready.
	input wire logic               pslverr,   // Error.
	input wire tws_pkg::tws_line_t pin_in,    // Wires.
	input wire tws_pkg::tws_line_t pin_out,   // Pin values.
	input wire tws_pkg::tws_line_t pin_oe_n,  // Pin enables.
	input wire logic               pins_owned // Pins taken.
);
	// ****************
	// Checks
	// ****************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic ctl_wr;
	assign ctl_wr = psel && penable && pwrite && paddr == tws_pkg::OFS_CTRL1;
	ready_follow_a:
		assert property (pready == (psel && penable)) else $error("pready mismatch");
	unmapped_err_a:
		assert property (psel && penable && paddr > 8'h18 |-> pslverr) else $error("no pslverr");
	upper_zero_a:
		assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits set");
	low_only_a:
		assert property (pin_out == 2'h0) else $error("pin value high");
	owned_drive_a:
		assert property (pin_oe_n != 2'h3 |-> pins_owned) else $error("pin driven while off");
	enable_own_a:
		assert property (ctl_wr && pwdata[5] |=> pins_owned) else $error("pins not taken");
	disable_free_a:
		assert property (ctl_wr && !pwdata[5] |=> !pins_owned && pin_oe_n == 2'h3) else $error("pins kept");
	start_clock_a:
		assert property ($fell(pin_oe_n.sda) && pin_oe_n.scl && pin_in.scl |-> ##[1:200] !pin_oe_n.scl)
		else $error("start without clock low");
	cover property (psel && penable && pslverr);
	cover property ($fell(pin_oe_n.sda) && pin_in.scl);
	cover property (!pin_oe_n.scl && pins_owned);
endmodule : tws_ctrl_sva

bind tws_ctrl tws_ctrl_sva #(.AW(AW)) u_sva (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
	.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pins_owned(pins_owned)
);

// ---- tws_peer.sv ----
`timescale 1ns/10ps
module tws_peer (
	input  wire logic       pclk,    // Clock.
	input  wire logic       presetn, // Reset.
	input  wire logic       scl,     // Clock wire.
	input  wire logic       sda,     // Data wire.
	input  wire logic       ack_en,  // Acknowledge bytes.
	input  wire logic       stretch, // Hold clock in ack slot.
	input  wire logic       rx_on,   // Send rd_byte.
	input  wire logic [7:0] rd_byte, // Byte to send.
	output logic            scl_low, // Pull clock low.
	output logic            sda_low  // Pull data low.
);
	// ****************
	// Bit slot tracking
	// ****************
	logic [3:0] cnt;
	logic       scl_d;
	logic       sda_d;
	// Slot 9 is the acknowledge; the next fall opens bit one of the next byte.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{cnt, scl_d, sda_d} <= 6'h00;
		end else begin
			scl_d <= scl;
			sda_d <= sda;
			if (scl && sda_d && !sda) begin
				cnt <= 4'h0;
			end else if (scl_d && !scl) begin
				cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
			end
		end
	end
	always_comb begin
		sda_low = rx_on ? (cnt inside {[4'h1:4'h8]} && !rd_byte[3'(4'h8 - cnt)]) : (ack_en && cnt == 4'h9);
		scl_low = stretch && cnt == 4'h9;
	end
endmodule : tws_peer

// ---- two_wire_serial_port_control_tb.sv ----
`timescale 1ns/10ps
module two_wire_serial_port_control_tb;
	// ****************
	// Bench state
	// ****************
	logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, pins_owned;
	logic               p_scl, p_sda, ack_en, stretch, rx_on, scl_q, ls, e;
	logic [7:0]         paddr, rb;
	logic [31:0]        pwdata, prdata, r;
	int                 failures, checks_done, cyc, last, per;
	tws_pkg::tws_line_t pin_in, pin_out, pin_oe_n;

	// Released wires rise through the pull-ups, so any party may pull low.
	assign pin_in = {pin_oe_n.scl & ~p_scl, pin_oe_n.sda & ~p_sda};
	always #20 pclk = ~pclk;

	tws_ctrl #(.AW(8)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pins_owned(pins_owned)
	);
	tws_peer u_peer (
		.pclk(pclk), .presetn(presetn), .scl(pin_in.scl), .sda(pin_in.sda), .ack_en(ack_en),
		.stretch(stretch), .rx_on(rx_on), .rd_byte(rb), .scl_low(p_scl), .sda_low(p_sda)
	);

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task wrap_up;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		{e, r} = {pslverr, prdata};
		{psel, penable} <= 2'b00;
	endtask : apb

	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(r & m, x);
	endtask : rd

	task poll(input logic [7:0] a, input logic [31:0] m);
		do apb(1'b0, a, 32'h0); while ((r & m) != 32'h0);
	endtask : poll

	// The period is measured between clock rises as seen on the wire.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		scl_q <= pin_in.scl;
		if (pin_in.scl && !scl_q) begin
			per <= cyc - last;
			last <= cyc;
			ls <= pin_in.sda;
		end
		if (cyc == 20000) begin
			failures++;
			wrap_up;
		end
	end

	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata, ack_en, stretch, rx_on, rb} = '0;
		{scl_q, ls, failures, checks_done, cyc, last, per} = '0;
		void'($urandom(32'hDE36));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			rd(8'(i * 4), 32'hFF, (i == 6) ? 32'h3 : 32'h0);
		end
		apb(1'b0, 8'h1C, 32'h0);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
		apb(1'b1, 8'h10, 32'h2);
		apb(1'b1, 8'h04, 32'h28);
		rd(8'h04, 32'hFF, 32'h28);
		chk(pins_owned, 32'h1);
		apb(1'b1, 8'h0C, {24'h0, 8'($urandom)});
		rd(8'h04, 32'h80, 32'h80);
		apb(1'b1, 8'h04, 32'h28);
		rd(8'h04, 32'h80, 32'h0);
		apb(1'b1, 8'h08, 32'h1);
		apb(1'b1, 8'h08, 32'h4);
		rd(8'h08, 32'h1F, 32'h1);
		poll(8'h08, 32'h1F);
		rd(8'h00, 32'h18, 32'h08);
		rd(8'h14, 32'h1, 32'h1);
		apb(1'b1, 8'h14, 32'h1);
		ack_en <= 1'b1;
		apb(1'b1, 8'h0C, {24'h0, 8'($urandom)});
		rd(8'h00, 32'h4, 32'h4);
		rd(8'h14, 32'h2, 32'h2);
		poll(8'h00, 32'h4);
		rd(8'h08, 32'h40, 32'h0);
		chk(per, 32'hC);
		ack_en <= 1'b0;
		apb(1'b1, 8'h0C, {24'h0, 8'($urandom)});
		poll(8'h00, 32'h4);
		rd(8'h08, 32'h40, 32'h40);
		rb <= 8'($urandom);
		rx_on <= 1'b1;
		apb(1'b1, 8'h08, 32'h8);
		poll(8'h08, 32'h8);
		rx_on <= 1'b0;
		rd(8'h00, 32'h1, 32'h1);
		rd(8'h0C, 32'hFF, {24'h0, rb});
		rd(8'h00, 32'h1, 32'h0);
		stretch <= 1'b1;
		apb(1'b1, 8'h08, 32'h30);
		repeat (4) rd(8'h08, 32'h10, 32'h10);
		stretch <= 1'b0;
		poll(8'h08, 32'h10);
		rd(8'h08, 32'h30, 32'h20);
		chk(ls, 32'h1);
		apb(1'b1, 8'h08, 32'h4);
		poll(8'h08, 32'h4);
		rd(8'h00, 32'h18, 32'h10);
		apb(1'b1, 8'h04, 32'h2B);
		apb(1'b1, 8'h08, 32'h1);
		poll(8'h08, 32'h1F);
		rd(8'h00, 32'h18, 32'h08);
		apb(1'b1, 8'h04, 32'h08);
		rd(8'h00, 32'h18, 32'h0);
		chk(pins_owned, 32'h0);
		apb(1'b1, 8'h04, 32'h29);
		apb(1'b1, 8'h08, 32'h1);
		rd(8'h00, 32'h18, 32'h0);
		chk(pin_oe_n, 32'h3);
		wrap_up;
	end
endmodule : two_wire_serial_port_control_tb
